// *** src/pcq_defs.vh ***
// constants for the probe clock qualifier self-test block
// assumes a host port with 8-bit data and 4-bit addresses
`ifndef PCQ_DEFS_VH
`define PCQ_DEFS_VH

// write offsets: port write strobes 0..5, then control ports
`define PCQ_STROBE_POD_A_SEL  4'h0
`define PCQ_STROBE_POD_A_QUAL 4'h1
`define PCQ_STROBE_POD_B_SEL  4'h2
`define PCQ_STROBE_POD_B_QUAL 4'h3
`define PCQ_STROBE_POD_C_SEL  4'h4
`define PCQ_STROBE_POD_C_QUAL 4'h5
`define PCQ_ADDR_CLK_INIT     4'h6
`define PCQ_ADDR_THRESHOLD    4'h7
`define PCQ_ADDR_COUNT_LOAD   4'h8
`define PCQ_ADDR_COUNT_CTRL   4'h9
// read offsets
`define PCQ_ADDR_COUNT_LOW    4'h3
`define PCQ_ADDR_COUNT_HIGH   4'h4
`define PCQ_ADDR_SIGNAL_ID    4'hA

// field positions
`define PCQ_SRC_ENABLE_BIT    6
`define PCQ_INIT_BIT          0
`define PCQ_COUNT_EN_BIT      0

// reset values
`define PCQ_SEL_RESET         7'h00
`define PCQ_QUAL_RESET        6'h00
`define PCQ_THR_RESET         8'h80
`define PCQ_COUNT_RESET       12'h000
`define PCQ_COUNT_EN_RESET    1'b1
`define PCQ_SIGNAL_RESET      3'h0

// threshold below this makes a floating probe read high
`define PCQ_THR_MID           8'h80

`endif

// *** src/pcq_clock_cell.v ***
// one clock generator flip-flop with its select gate and init set
// assumes all inputs come from logic on clk
`timescale 1ns/10ps
`default_nettype none
module pcq_clock_cell (
  input  wire clk,
  input  wire rstn,
  input  wire ce,
  input  wire initSet,
  input  wire commonClk,
  input  wire selectBit,
  input  wire qualBit,
  output reg  clockPulse
);
  reg  clkNetPrev_reg;
  reg  setState_reg;
  wire clkNet;
  wire clkRise;

  // select bit only clocks while the common input sits low
  assign clkNet  = commonClk | selectBit;
  assign clkRise = clkNet & ~clkNetPrev_reg;

  // flip-flop: set by one-shot, clocked with the qualifier as data
  always @(posedge clk) begin
    if (!rstn) begin
      clkNetPrev_reg <= 1'b1;
      setState_reg   <= 1'b1;
      clockPulse     <= 1'b0;
    end else if (ce) begin
      clkNetPrev_reg <= clkNet;
      clockPulse     <= 1'b0;
      if (initSet) begin
        setState_reg <= 1'b1;
      end else if (clkRise) begin
        setState_reg <= qualBit;
        clockPulse   <= setState_reg & ~qualBit;
      end
    end
  end
endmodule // pcq_clock_cell
`default_nettype wire

// *** src/pcq_self_test.v ***
// probe clock generator and qualifier path with host port
// assumes probe pins are asynchronous, host port runs on clk
`timescale 1ns/10ps
`default_nettype none
`include "pcq_defs.vh"
module pcq_self_test #(
  parameter COUNT_WIDTH = 12,
  parameter CELLS       = 18
) (
  input  wire       clk,
  input  wire       rstn,
  input  wire       ce,
  input  wire [3:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWr,
  input  wire       regRd,
  output reg  [7:0] regRdData,
  input  wire       probeAClock,
  input  wire       probeBClock,
  input  wire       probeCClock,
  output reg  [COUNT_WIDTH-1:0] acquisitionAddressCounter
);
  reg  [2:0] probeSync1_reg;
  reg  [2:0] probeSync2_reg;
  reg  [6:0] podClockSelect_reg [0:2];
  reg  [5:0] qualifierEnable_reg [0:2];
  reg  [7:0] threshold_reg;
  reg        countEnable_reg;
  reg  [2:0] signalUnderTest_reg;
  reg  [5:0] initShot_reg;
  reg  [2:0] probeLevel_reg;
  wire [5:0] commonClk;
  wire [CELLS-1:0] cellPulse;
  wire       thrLow;
  reg  [4:0] pulseCount;
  reg  [2:0] signalNext;
  wire [2:0] sourceEnable;
  integer    i;
  integer    j;
  integer    k;

  // probe pins pass two flops before the receivers look at them
  always @(posedge clk) begin
    if (!rstn) begin
      probeSync1_reg <= 3'h0;
      probeSync2_reg <= 3'h0;
    end else if (ce) begin
      probeSync1_reg <= {probeCClock, probeBClock, probeAClock};
      probeSync2_reg <= probeSync1_reg;
    end
  end

  // receivers: a low threshold makes floating leads read high
  assign thrLow = (threshold_reg < `PCQ_THR_MID);
  always @(posedge clk) begin
    if (!rstn) begin
      probeLevel_reg <= 3'h0;
    end else if (ce) begin
      probeLevel_reg <= probeSync2_reg | {3{thrLow}};
    end
  end

  // clock mux: signal s follows probe s/2, odd s inverted; threshold reaches flops even when deselected
  genvar s;
  generate
    for (s = 0; s < 6; s = s + 1) begin : gMux
      assign commonClk[s] = probeLevel_reg[s/2] ^ (s % 2 == 1);
    end
  endgenerate

  // bit 6 of each source register passes that source's clocks on; no edge on deselect
  assign sourceEnable = {podClockSelect_reg[2][`PCQ_SRC_ENABLE_BIT],
                         podClockSelect_reg[1][`PCQ_SRC_ENABLE_BIT],
                         podClockSelect_reg[0][`PCQ_SRC_ENABLE_BIT]};

  // eighteen generator flip-flops: three pods by six clock signals
  genvar g;
  generate
    for (g = 0; g < CELLS; g = g + 1) begin : gCell
      pcq_clock_cell uCell (
        .clk        (clk),
        .rstn       (rstn),
        .ce         (ce),
        .initSet    (initShot_reg[g % 6]),
        .commonClk  (commonClk[g % 6]),
        .selectBit  (podClockSelect_reg[g / 6][g % 6]),
        .qualBit    (qualifierEnable_reg[g / 6][g % 6]),
        .clockPulse (cellPulse[g])
      );
    end
  endgenerate

  // count pulses that land in the same cycle, only from selected sources
  always @* begin
    pulseCount = 5'h00;
    for (j = 0; j < CELLS; j = j + 1) begin
      pulseCount = pulseCount + {4'h0, cellPulse[j] & sourceEnable[(j % 6) / 2]};
    end
  end

  // most recent select bit raised names the signal under test
  always @* begin
    signalNext = signalUnderTest_reg;
    for (k = 0; k < 6; k = k + 1) begin
      if (regWr && !regAddr[0] && regAddr < 4'h6 && regWrData[k]) begin
        signalNext = k[2:0];
      end
    end
  end

  // port write strobes: even ones load clock selects, odd ones qualifiers
  always @(posedge clk) begin
    if (!rstn) begin
      for (i = 0; i < 3; i = i + 1) begin
        podClockSelect_reg[i]  <= `PCQ_SEL_RESET;
        qualifierEnable_reg[i] <= `PCQ_QUAL_RESET;
      end
      signalUnderTest_reg <= `PCQ_SIGNAL_RESET;
    end else if (ce && regWr) begin
      case (regAddr)
        `PCQ_STROBE_POD_A_SEL:  podClockSelect_reg[0]  <= regWrData[6:0];
        `PCQ_STROBE_POD_B_SEL:  podClockSelect_reg[1]  <= regWrData[6:0];
        `PCQ_STROBE_POD_C_SEL:  podClockSelect_reg[2]  <= regWrData[6:0];
        `PCQ_STROBE_POD_A_QUAL: qualifierEnable_reg[0] <= regWrData[5:0];
        `PCQ_STROBE_POD_B_QUAL: qualifierEnable_reg[1] <= regWrData[5:0];
        `PCQ_STROBE_POD_C_QUAL: qualifierEnable_reg[2] <= regWrData[5:0];
        default: ;
      endcase
      signalUnderTest_reg <= signalNext;
    end
  end

  // threshold, count enable and the initialise one-shots
  always @(posedge clk) begin
    if (!rstn) begin
      threshold_reg   <= `PCQ_THR_RESET;
      countEnable_reg <= `PCQ_COUNT_EN_RESET;
      initShot_reg    <= 6'h00;
    end else if (ce) begin
      initShot_reg <= 6'h00;
      if (regWr) begin
        case (regAddr)
          `PCQ_ADDR_THRESHOLD:  threshold_reg   <= regWrData;
          `PCQ_ADDR_COUNT_CTRL: countEnable_reg <= regWrData[`PCQ_COUNT_EN_BIT];
          `PCQ_ADDR_CLK_INIT: begin
            if (!regWrData[`PCQ_INIT_BIT]) begin
              initShot_reg <= 6'h3F;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // address counter: load wins over counting, one step per pulse
  always @(posedge clk) begin
    if (!rstn) begin
      acquisitionAddressCounter <= `PCQ_COUNT_RESET;
    end else if (ce) begin
      if (regWr && regAddr == `PCQ_ADDR_COUNT_LOAD) begin
        acquisitionAddressCounter <= {{(COUNT_WIDTH-8){1'b0}}, regWrData};
      end else if (countEnable_reg) begin
        acquisitionAddressCounter <= acquisitionAddressCounter
                                     + {{(COUNT_WIDTH-5){1'b0}}, pulseCount};
      end
    end
  end

  // readback: data stands in the cycle after the read strobe only
  always @(posedge clk) begin
    if (!rstn) begin
      regRdData <= 8'h00;
    end else if (ce) begin
      regRdData <= 8'h00;
      if (regRd) begin
        case (regAddr)
          `PCQ_ADDR_COUNT_LOW:  regRdData <= acquisitionAddressCounter[7:0];
          `PCQ_ADDR_COUNT_HIGH: regRdData <= {{(16-COUNT_WIDTH){1'b0}},
                                              acquisitionAddressCounter[COUNT_WIDTH-1:8]};
          `PCQ_ADDR_SIGNAL_ID:  regRdData <= {5'h00, signalUnderTest_reg};
          default:              regRdData <= 8'h00;
        endcase
      end
    end
  end
endmodule // pcq_self_test
`default_nettype wire

// *** test/pcq_self_test_properties.sv ***
// port checker for the probe clock self-test block
// assumes ce held high and a 12-bit or wider counter
`timescale 1ns/10ps
`default_nettype none
module pcq_self_test_properties #(
  parameter COUNT_WIDTH = 12
) (
  input wire logic                   clk,
  input wire logic                   rstn,
  input wire logic [3:0]             regAddr,
  input wire logic [7:0]             regWrData,
  input wire logic                   regWr,
  input wire logic                   regRd,
  input wire logic [7:0]             regRdData,
  input wire logic [COUNT_WIDTH-1:0] acquisitionAddressCounter
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [3:0] quietReg;
  // cycles since the last host write, saturating
  always @(posedge clk) begin
    if (!rstn || regWr) quietReg <= 4'h0;
    else if (quietReg != 4'hF) quietReg <= quietReg + 4'h1;
  end
  sequence s_load; regWr && regAddr == 4'h8; endsequence
  sequence s_inc; acquisitionAddressCounter == $past(acquisitionAddressCounter) + 1'b1; endsequence
  property p_rd_low; regRd && regAddr == 4'h3 |=> regRdData == $past(acquisitionAddressCounter[7:0]); endproperty
  property p_rd_high; regRd && regAddr == 4'h4 |=> regRdData == 8'($past(acquisitionAddressCounter) >> 8); endproperty
  property p_rd_idle; !regRd |=> regRdData == 8'h00; endproperty
  property p_rd_unmapped; regRd && !(regAddr inside {4'h3, 4'h4, 4'hA}) |=> regRdData == 8'h00; endproperty
  property p_load; s_load |=> acquisitionAddressCounter == COUNT_WIDTH'($past(regWrData)); endproperty
  property p_step; !(regWr && regAddr == 4'h8) |=> $stable(acquisitionAddressCounter) or s_inc; endproperty
  property p_caused; s_inc |-> quietReg < 4'hC; endproperty
  property p_single; s_inc |=> not s_inc; endproperty
  a_rd_low: assert property (p_rd_low) else $error("low byte readback wrong");
  a_rd_high: assert property (p_rd_high) else $error("high readback wrong");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  a_load: assert property (p_load) else $error("counter load wrong");
  a_step: assert property (p_step) else $error("counter moved by more than one");
  a_caused: assert property (p_caused) else $error("clock without host activity");
  a_single: assert property (p_single) else $error("clock pulse too long");
endmodule // pcq_self_test_properties
bind pcq_self_test pcq_self_test_properties #(.COUNT_WIDTH(COUNT_WIDTH)) chk (.clk(clk), .rstn(rstn),
  .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
  .acquisitionAddressCounter(acquisitionAddressCounter));
`default_nettype wire

// *** test/pcq_probe_leads.sv ***
// far side model: three probe leads left unconnected
// assumes open leads settle low at the receivers
`timescale 1ns/10ps
`default_nettype none
module pcq_probe_leads (
  output wire logic leadA,
  output wire logic leadB,
  output wire logic leadC
);
  // open leads; only the threshold moves the receivers
  assign leadA = 1'b0;
  assign leadB = 1'b0;
  assign leadC = 1'b0;
endmodule // pcq_probe_leads
`default_nettype wire

// *** test/pcq_self_test_bench.sv ***
// bench: host sequencer for the probe clock checks
// assumes probe lead model and bound checker
`timescale 1ns/10ps
`default_nettype none
`include "pcq_defs.vh"
module pcq_self_test_bench;
  logic        clk = 1'b0, rstn = 1'b0, regWr = 1'b0, regRd = 1'b0, rdSeen = 1'b0;
  logic [3:0]  regAddr = 4'h0, srcA, selA, qualA;
  logic [7:0]  regWrData = 8'h00, rdExp, bitMask, thrOff;
  logic [7:0]  expQ[$];
  wire  [7:0]  regRdData;
  wire  [11:0] counter;
  wire         leadA, leadB, leadC;
  int          failures = 0, compares = 0, p, s;
  always #10 clk = ~clk;
  pcq_probe_leads leads (.leadA(leadA), .leadB(leadB), .leadC(leadC));
  pcq_self_test #(.COUNT_WIDTH(12), .CELLS(18)) dut (.clk(clk), .rstn(rstn), .ce(1'b1), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .probeAClock(leadA),
    .probeBClock(leadB), .probeCClock(leadC), .acquisitionAddressCounter(counter));
  task report_and_stop;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    expQ.push_back(e);
    @(posedge clk);
    regRd <= 1'b0;
  endtask
  // enable the source and set the select bit, then let the receivers settle
  task pick(input logic [7:0] en, input logic [7:0] b);
    if (srcA == selA) wr(selA, en | b);
    else begin
      wr(srcA, en);
      wr(selA, b);
    end
    repeat (6) @(posedge clk);
  endtask
  // threshold change followed by flip-flop init
  task thr(input logic [7:0] t);
    wr(`PCQ_ADDR_THRESHOLD, t);
    repeat (6) @(posedge clk);
    wr(`PCQ_ADDR_CLK_INIT, 8'h00);
  endtask
  task cmp(input logic [7:0] e);
    compares++;
    if (regRdData !== e) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, regRdData, e);
    end
  endtask
  // read data stands in the cycle after the strobe
  always @(posedge clk) begin
    if (rdSeen) cmp(expQ.pop_front());
    rdSeen <= regRd;
  end
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'h3123));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rdExp = 8'($urandom);
    wr(`PCQ_ADDR_COUNT_LOAD, rdExp);
    rd(`PCQ_ADDR_COUNT_LOW, rdExp);
    rd(`PCQ_ADDR_COUNT_HIGH, 8'h00);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    for (p = 0; p < 3; p++) for (s = 0; s < 6; s++) begin
      srcA = 4'(s / 2 * 2);
      selA = 4'(p * 2);
      qualA = selA + 4'h1;
      bitMask = 8'(1 << s);
      thrOff = s[0] ? 8'hFF : 8'h00;
      wr(`PCQ_ADDR_CLK_INIT, 8'h00);
      for (int a = 0; a < 6; a++) wr(4'(a), (a == 0 || a == 2) ? 8'h80 : 8'h00);
      wr(`PCQ_ADDR_COUNT_LOAD, 8'h00);
      thr(thrOff);
      pick(8'h40, 8'h00);
      pick(8'h40, bitMask);
      pick(8'h40, 8'h00);
      rd(`PCQ_ADDR_COUNT_LOW, 8'h00);
      pick(8'h00, 8'h00);
      wr(`PCQ_ADDR_COUNT_LOAD, 8'h00);
      thr(~thrOff);
      wr(qualA, bitMask);
      pick(8'h40, 8'h00);
      pick(8'h40, bitMask);
      pick(8'h40, 8'h00);
      rd(`PCQ_ADDR_COUNT_LOW, 8'h00);
      wr(`PCQ_ADDR_COUNT_LOAD, 8'h00);
      wr(qualA, 8'h00);
      pick(8'h40, bitMask);
      pick(8'h00, 8'h00);
      wr(`PCQ_ADDR_CLK_INIT, 8'h00);
      pick(8'h40, 8'h00);
      pick(8'h40, bitMask);
      pick(8'h40, 8'h00);
      rd(`PCQ_ADDR_COUNT_LOW, 8'h02);
      rd(`PCQ_ADDR_SIGNAL_ID, 8'(s));
    end
    repeat (4) @(posedge clk);
    report_and_stop;
  end
endmodule // pcq_self_test_bench
`default_nettype wire
